// *** smr_pkg.sv ***
package smr_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ      = 25_000_000;
  localparam int TIMEOUT_MS  = 35;
  // longest time: rounds down to whole cycles
  localparam int TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;

  // ----------------------------------------
  // slave addresses chosen by the straps
  // ----------------------------------------
  localparam logic [6:0] ADDR_DEFAULT  = 7'h2e;
  localparam logic [6:0] ADDR_SEL_LOW  = 7'h2c;
  localparam logic [6:0] ADDR_SEL_HIGH = 7'h2d;

  // ----------------------------------------
  // byte framing and pointer
  // ----------------------------------------
  localparam logic [7:0] PTR_RESET     = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ADDR_LAST_BIT = 4'h7;
  localparam logic [1:0] MAX_WR_BYTES  = 2'h2;
  localparam logic [1:0] STRAP_WAIT    = 2'h3;
  localparam logic       DIR_READ      = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_ACK_A  = 3'b010,
    ST_WR     = 3'b011,
    ST_ACK_W  = 3'b100,
    ST_RD     = 3'b101,
    ST_RACK   = 3'b110,
    ST_IGNORE = 3'b111
  } smr_state_e;

endpackage

// *** smr_mem_if.sv ***
`timescale 1ns/10ps
interface smr_mem_if #(
  parameter int AW = 8,
  parameter int DW = 8
) ();
  logic          wr_en;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;

  modport host (output wr_en, output addr, output wdata, input rdata);
  modport mem  (input wr_en, input addr, input wdata, output rdata);
endinterface

// *** smr_sync.sv ***
`timescale 1ns/10ps
module smr_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  generate
    if (W < 1) begin : g_bad_w
      $error("smr_sync: width must be at least one");
    end
  endgenerate

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= INIT;
      q        <= INIT;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// *** smr_regmem.sv ***
`timescale 1ns/10ps
module smr_regmem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // access port
  smr_mem_if.mem    mp
);

  logic [DW-1:0] mem_reg [0:(1<<AW)-1];
  logic [DW-1:0] rdata_reg;

  generate
    if (AW < 1 || DW < 1) begin : g_bad_size
      $error("smr_regmem: address and data widths must be positive");
    end
  endgenerate

  // array itself has no reset so it maps onto plain storage
  always_ff @(posedge clk) begin
    if (mp.wr_en) begin
      mem_reg[mp.addr] <= mp.wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= mem_reg[mp.addr];
    end
  end

  assign mp.rdata = rdata_reg;

endmodule

// *** smr_slave.sv ***
`timescale 1ns/10ps
// Function
// - strap enable high at power-up: answer to default address, select pin ignored
// - strap enable low: select pin low or high picks one of two addresses
// - straps sampled once after reset; addr_locked set at 8th rise of first match
// - start condition begins a transfer; seven address bits MSB first, then direction
// - only a matching slave acknowledges; others stay idle until next start or stop
// - direction bit zero writes into the slave, one reads from it
// - nine clocks per byte; SDA changes only while SCL is low
// - a transfer is all read or all write until a new start
// - accept one or two write bytes; return exactly one read byte
// - first write byte loads pointer; second byte stored where pointer selects
// - pointer-only write changes no data register
// - read returns the register selected by the current pointer
// - repeated start is handled as the start of a new transfer
// - send byte, receive byte and read byte transactions are supported
// - release the bus after 35 ms without activity unless disabled
module smr_slave
  import smr_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  // clocks and reset
  input  wire logic clk,
  input  wire logic link_clk,
  input  wire logic rstn,
  // serial bus pins
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  // straps and configuration
  input  wire logic address_strap_enable,
  input  wire logic address_select,
  input  wire logic bus_timeout_disable,
  // status
  output logic      addr_locked
);

  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [TW-1:0] TO_LAST = TW'(TIMEOUT_CYCLES - 1);
  localparam logic [TW-1:0] TO_FULL = TW'(TIMEOUT_CYCLES);

  generate
    if (TIMEOUT_CYCLES < 2) begin : g_bad_timeout
      $error("smr_slave: timeout count must be at least two");
    end
  endgenerate

  // ----------------------------------------
  // link domain: pin sampling
  // ----------------------------------------
  logic [3:0] pin_s;
  logic       to_s;
  logic       ack_s;
  logic       to_tgl_reg;
  logic       ack_tgl_reg;
  logic [7:0] rd_hold_reg;

  smr_sync #(.W(4), .INIT(4'hc)) u_pin_sync (
    .clk  (link_clk),
    .rstn (rstn),
    .d    ({scl_i, sda_i, address_strap_enable, address_select}),
    .q    (pin_s)
  );

  smr_sync #(.W(2), .INIT(2'h0)) u_ret_sync (
    .clk  (link_clk),
    .rstn (rstn),
    .d    ({to_tgl_reg, ack_tgl_reg}),
    .q    ({to_s, ack_s})
  );

  smr_state_e state_reg;
  smr_state_e state_next;
  logic       oe_next;
  logic       scl_d_reg;
  logic       sda_d_reg;
  logic       to_d_reg;
  logic       ack_d_reg;
  logic [3:0] bit_cnt_reg;
  logic [1:0] byte_cnt_reg;
  logic [7:0] shift_reg;
  logic       rw_reg;
  logic       hit_reg;
  logic [7:0] ptr_reg;
  logic [6:0] slave_addr_reg;
  logic [1:0] strap_cnt_reg;
  logic       strap_taken_reg;
  logic       strap_en_reg;
  logic       strap_sel_reg;
  logic       addr_locked_reg;
  logic       sda_oe_reg;
  logic       sda_o_reg;
  logic       req_tgl_reg;
  logic       req_wr_reg;
  logic [7:0] req_addr_reg;
  logic [7:0] req_data_reg;
  logic [7:0] rx_data_reg;
  logic       act_tgl_reg;

  wire scl_s       = pin_s[3];
  wire sda_s       = pin_s[2];
  wire start_ev    = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_ev     = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire scl_rise    = scl_s & ~scl_d_reg;
  wire scl_fall    = ~scl_s & scl_d_reg;
  wire to_ev       = to_s ^ to_d_reg;
  wire ack_ev      = ack_s ^ ack_d_reg;
  wire byte_done   = scl_fall & (bit_cnt_reg == BITS_PER_BYTE);
  wire shifting    = (state_reg == ST_ADDR) | (state_reg == ST_WR) | (state_reg == ST_RD);
  wire addr_rise8  = (state_reg == ST_ADDR) & scl_rise & (bit_cnt_reg == ADDR_LAST_BIT);
  wire match_now   = addr_rise8 & strap_taken_reg & (shift_reg[6:0] == slave_addr_reg);
  wire wr_byte_ok  = byte_cnt_reg < MAX_WR_BYTES;
  wire ptr_load    = (state_reg == ST_WR) & byte_done & (byte_cnt_reg == 2'h0);
  wire data_store  = (state_reg == ST_WR) & byte_done & (byte_cnt_reg == 2'h1);
  wire rd_fetch    = match_now & (sda_s == DIR_READ);
  wire req_fire    = data_store | rd_fetch;
  wire tx_load     = (state_reg == ST_ACK_A) & scl_fall & rw_reg;
  wire tx_shift    = (state_reg == ST_RD) & scl_fall & (bit_cnt_reg != BITS_PER_BYTE);
  wire cnt_clear   = start_ev | ((state_reg == ST_ACK_A) | (state_reg == ST_ACK_W)) & scl_fall;
  wire [6:0] strap_addr = strap_en_reg ? ADDR_DEFAULT :
                          (strap_sel_reg ? ADDR_SEL_HIGH : ADDR_SEL_LOW);

  // ----------------------------------------
  // byte engine
  // ----------------------------------------
  // stop and timeout outrank everything; a start restarts from any state
  always_comb begin
    state_next = state_reg;
    oe_next    = sda_oe_reg;
    if (to_ev | stop_ev) begin
      state_next = ST_IDLE;
      oe_next    = 1'b0;
    end else if (start_ev) begin
      state_next = ST_ADDR;
      oe_next    = 1'b0;
    end else begin
      case (state_reg)
        ST_ADDR: if (byte_done) begin
          state_next = hit_reg ? ST_ACK_A : ST_IGNORE;
          oe_next    = hit_reg;
        end
        ST_ACK_A: if (scl_fall) begin
          state_next = rw_reg ? ST_RD : ST_WR;
          oe_next    = rw_reg & ~rx_data_reg[7];
        end
        ST_WR: if (byte_done) begin
          state_next = wr_byte_ok ? ST_ACK_W : ST_IGNORE;
          oe_next    = wr_byte_ok;
        end
        ST_ACK_W: if (scl_fall) begin
          state_next = ST_WR;
          oe_next    = 1'b0;
        end
        ST_RD: if (byte_done) begin
          state_next = ST_RACK;
          oe_next    = 1'b0;
        end else if (tx_shift) begin
          oe_next = ~shift_reg[7];
        end
        ST_RACK: if (scl_rise) begin
          state_next = ST_IGNORE;
        end
        ST_IDLE, ST_IGNORE: begin
          state_next = state_reg;
        end
        default: begin
          state_next = ST_IDLE;
          oe_next    = 1'b0;
        end
      endcase
    end
  end

  wire [7:0] shift_next = tx_load  ? {rx_data_reg[6:0], 1'b0} :
                          tx_shift ? {shift_reg[6:0], 1'b0} :
                          (scl_rise & shifting & (state_reg != ST_RD)) ? {shift_reg[6:0], sda_s} :
                          shift_reg;
  wire [3:0] bit_next   = cnt_clear ? 4'h0 :
                          (scl_rise & shifting) ? bit_cnt_reg + 4'h1 : bit_cnt_reg;
  wire [1:0] byte_next  = start_ev ? 2'h0 :
                          ((state_reg == ST_WR) & byte_done & wr_byte_ok) ? byte_cnt_reg + 2'h1 :
                          byte_cnt_reg;

  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg    <= ST_IDLE;
      sda_oe_reg   <= 1'b0;
      sda_o_reg    <= 1'b0;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
      to_d_reg     <= 1'b0;
      ack_d_reg    <= 1'b0;
      bit_cnt_reg  <= 4'h0;
      byte_cnt_reg <= 2'h0;
      shift_reg    <= 8'h00;
      act_tgl_reg  <= 1'b0;
    end else begin
      state_reg    <= state_next;
      sda_oe_reg   <= oe_next;
      sda_o_reg    <= 1'b0;
      scl_d_reg    <= scl_s;
      sda_d_reg    <= sda_s;
      to_d_reg     <= to_s;
      ack_d_reg    <= ack_s;
      bit_cnt_reg  <= bit_next;
      byte_cnt_reg <= byte_next;
      shift_reg    <= shift_next;
      act_tgl_reg  <= act_tgl_reg ^ (scl_rise | scl_fall);
    end
  end

  // ----------------------------------------
  // address strap, match and pointer
  // ----------------------------------------
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      strap_cnt_reg   <= 2'h0;
      strap_taken_reg <= 1'b0;
      strap_en_reg    <= 1'b0;
      strap_sel_reg   <= 1'b0;
      slave_addr_reg  <= ADDR_DEFAULT;
      addr_locked_reg <= 1'b0;
      hit_reg         <= 1'b0;
      rw_reg          <= 1'b0;
      ptr_reg         <= PTR_RESET;
    end else begin
      // wait for the synchroniser to fill before trusting the straps
      if (strap_cnt_reg != STRAP_WAIT) begin
        strap_cnt_reg <= strap_cnt_reg + 2'h1;
      end else if (!strap_taken_reg) begin
        strap_taken_reg <= 1'b1;
        strap_en_reg    <= pin_s[1];
        strap_sel_reg   <= pin_s[0];
      end
      if (strap_cnt_reg == STRAP_WAIT && !strap_taken_reg) begin
        slave_addr_reg <= pin_s[1] ? ADDR_DEFAULT : (pin_s[0] ? ADDR_SEL_HIGH : ADDR_SEL_LOW);
      end
      if (match_now) begin
        addr_locked_reg <= 1'b1;
      end
      if (start_ev) begin
        hit_reg <= 1'b0;
      end else if (addr_rise8) begin
        hit_reg <= match_now;
        rw_reg  <= sda_s;
      end
      if (ptr_load) begin
        ptr_reg <= shift_reg;
      end
    end
  end

  // ----------------------------------------
  // requests to the register store
  // ----------------------------------------
  // read is fetched at the address byte so data waits a full ack bit
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      req_tgl_reg  <= 1'b0;
      req_wr_reg   <= 1'b0;
      req_addr_reg <= 8'h00;
      req_data_reg <= 8'h00;
      rx_data_reg  <= 8'h00;
    end else begin
      if (req_fire) begin
        req_tgl_reg  <= ~req_tgl_reg;
        req_wr_reg   <= data_store;
        req_addr_reg <= ptr_reg;
        req_data_reg <= shift_reg;
      end
      if (ack_ev) begin
        rx_data_reg <= rd_hold_reg;
      end
    end
  end

  assign sda_o       = sda_o_reg;
  assign sda_oe      = sda_oe_reg;
  assign addr_locked = addr_locked_reg;

  // ----------------------------------------
  // system domain: store access and timeout
  // ----------------------------------------
  logic          req_s;
  logic          act_s;
  logic          bus_timeout_disable_s;
  logic          req_d_reg;
  logic          act_d_reg;
  logic          wr_en_reg;
  logic [TW-1:0] to_cnt_reg;

  smr_sync #(.W(3), .INIT(3'h0)) u_sys_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    ({req_tgl_reg, act_tgl_reg, bus_timeout_disable}),
    .q    ({req_s, act_s, bus_timeout_disable_s})
  );

  smr_mem_if #(.AW(8), .DW(8)) mif ();

  smr_regmem #(.AW(8), .DW(8)) u_regmem (
    .clk  (clk),
    .rstn (rstn),
    .mp   (mif.mem)
  );

  wire req_ev  = req_s ^ req_d_reg;
  wire act_ev  = act_s ^ act_d_reg;
  // fires once per silent period; the counter parks at full
  wire to_fire = ~bus_timeout_disable_s & ~act_ev & (to_cnt_reg == TO_LAST);
  wire [TW-1:0] to_cnt_next = (act_ev | bus_timeout_disable_s) ? '0 :
                              (to_cnt_reg == TO_FULL) ? to_cnt_reg : to_cnt_reg + 1'b1;

  // req_addr and req_data are held still by the toggle protocol
  assign mif.wr_en = wr_en_reg;
  assign mif.addr  = req_addr_reg;
  assign mif.wdata = req_data_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      req_d_reg   <= 1'b0;
      act_d_reg   <= 1'b0;
      wr_en_reg   <= 1'b0;
      ack_tgl_reg <= 1'b0;
      rd_hold_reg <= 8'h00;
      to_tgl_reg  <= 1'b0;
      to_cnt_reg  <= '0;
    end else begin
      req_d_reg   <= req_s;
      act_d_reg   <= act_s;
      wr_en_reg   <= req_ev & req_wr_reg;
      ack_tgl_reg <= ack_tgl_reg ^ req_ev;
      if (req_ev) begin
        rd_hold_reg <= mif.rdata;
      end
      to_tgl_reg  <= to_tgl_reg ^ to_fire;
      to_cnt_reg  <= to_cnt_next;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_default_addr: assert property (@(posedge link_clk) disable iff (!rstn)
    strap_taken_reg && strap_en_reg |-> slave_addr_reg == ADDR_DEFAULT)
    else $error("default address not used");
  a_select_addr: assert property (@(posedge link_clk) disable iff (!rstn)
    strap_taken_reg && !strap_en_reg |-> slave_addr_reg == strap_addr)
    else $error("select address wrong");
  a_addr_frozen: assert property (@(posedge link_clk) disable iff (!rstn)
    strap_taken_reg |=> $stable(slave_addr_reg) && strap_taken_reg)
    else $error("address changed after strap capture");
  a_restart_addr: assert property (@(posedge link_clk) disable iff (!rstn)
    start_ev && !stop_ev && !to_ev |=> state_reg == ST_ADDR && bit_cnt_reg == 4'h0)
    else $error("start did not restart address phase");
  a_ack_match: assert property (@(posedge link_clk) disable iff (!rstn)
    (state_reg == ST_ADDR) && byte_done |=> sda_oe_reg == $past(hit_reg))
    else $error("address acknowledge mismatch");
  a_ignore_quiet: assert property (@(posedge link_clk) disable iff (!rstn)
    state_reg == ST_IGNORE |-> !sda_oe_reg)
    else $error("driving while idle");
  a_oe_scl_low: assert property (@(posedge link_clk) disable iff (!rstn)
    $rose(sda_oe_reg) |-> !scl_s)
    else $error("SDA driven while SCL high");
  a_third_nak: assert property (@(posedge link_clk) disable iff (!rstn)
    (state_reg == ST_WR) && byte_done && !wr_byte_ok |=> !sda_oe_reg ##1 state_reg == ST_IGNORE)
    else $error("third write byte acknowledged");
  a_ptr_load: assert property (@(posedge link_clk) disable iff (!rstn)
    ptr_load |=> ptr_reg == $past(shift_reg))
    else $error("pointer not loaded");
  a_ptr_hold: assert property (@(posedge link_clk) disable iff (!rstn)
    !ptr_load |=> $stable(ptr_reg))
    else $error("pointer changed without load");
  a_read_ptr: assert property (@(posedge link_clk) disable iff (!rstn)
    rd_fetch |=> req_addr_reg == $past(ptr_reg) && !req_wr_reg)
    else $error("read not taken from pointer");
  a_read_dir: assert property (@(posedge link_clk) disable iff (!rstn)
    (state_reg == ST_RD) || (state_reg == ST_RACK) |-> rw_reg)
    else $error("read phase in write transfer");
  a_store_write: assert property (@(posedge clk) disable iff (!rstn)
    req_ev && req_wr_reg |=> wr_en_reg ##1 !wr_en_reg)
    else $error("data byte not stored");
  a_timeout_off: assert property (@(posedge clk) disable iff (!rstn)
    bus_timeout_disable_s |=> $stable(to_tgl_reg) && to_cnt_reg == '0)
    else $error("timeout while disabled");

endmodule

// *** smr_host_model.sv ***
`timescale 1ns/10ps
module smr_host_model (
  // clock
  input  wire logic clk,
  // bus lines, pulled up when released
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // ----------------------------------------
  // bus phases
  // ----------------------------------------
  // quarter bit: far longer than the device's pin synchroniser delay
  task automatic qtr();
    repeat (6) @(negedge clk);
  endtask

  task automatic start();
    sda_low <= 1'b0;
    qtr();
    scl_low <= 1'b0;
    qtr();
    sda_low <= 1'b1;
    qtr();
    scl_low <= 1'b1;
    qtr();
  endtask

  task automatic stop();
    sda_low <= 1'b1;
    qtr();
    scl_low <= 1'b0;
    qtr();
    sda_low <= 1'b0;
    qtr();
  endtask

  // data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    sda_low <= ~b;
    qtr();
    scl_low <= 1'b0;
    qtr();
    r = sda;
    qtr();
    scl_low <= 1'b1;
    qtr();
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, ack_n);
  endtask

  task automatic rd_byte(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(nak, r);
  endtask
endmodule

// *** smbus_slave_register_access_test.sv ***
`timescale 1ns/10ps
module smbus_slave_register_access_test
  import smr_pkg::*;
();
  logic       clk;
  logic       link_clk;
  logic       rstn;
  logic       strap_en;
  logic       strap_sel;
  logic       to_dis;
  logic       scl_low;
  logic       sda_low;
  logic       sda_o;
  logic       sda_oe;
  logic       addr_locked;
  wire        scl = ~scl_low;
  wire        sda = ~sda_low & (~sda_oe | sda_o);
  int         fails;
  int         checks;
  int         mem[int];
  int         ptr;
  int         wq[$];
  logic [6:0] my_addr;
  logic [7:0] p;
  logic [7:0] d;
  logic       r;

  smr_slave #(.TIMEOUT_CYCLES(200)) dut_u (
    .clk                 (clk),
    .link_clk            (link_clk),
    .rstn                (rstn),
    .scl_i               (scl),
    .sda_i               (sda),
    .sda_o               (sda_o),
    .sda_oe              (sda_oe),
    .address_strap_enable(strap_en),
    .address_select      (strap_sel),
    .bus_timeout_disable (to_dis),
    .addr_locked         (addr_locked)
  );

  smr_host_model host_u (
    .clk    (clk),
    .sda    (sda),
    .scl_low(scl_low),
    .sda_low(sda_low)
  );

  // ----------------------------------------
  // clocks and checking
  // ----------------------------------------
  always #20 clk = ~clk;
  always #3 link_clk = ~link_clk;

  task automatic chk_bit(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %0b seen %0b", n, e, g);
    end
  endtask

  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic results();
    if (fails == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // transfers
  // ----------------------------------------
  // straps only count at power-up, so every strap case needs its own reset
  task automatic reset_dut(input logic en, input logic sel);
    @(negedge clk);
    rstn      <= 1'b0;
    strap_en  <= en;
    strap_sel <= sel;
    repeat (3) @(negedge clk);
    rstn <= 1'b1;
    repeat (4) @(negedge clk);
    ptr = 0;
  endtask

  task automatic addr_ph(input logic [6:0] a, input logic rw, input logic exp_ack);
    logic an;
    host_u.start();
    host_u.wr_byte({a, rw}, an);
    chk_bit("address ack", exp_ack, ~an);
  endtask

  task automatic wr_dat(input logic [7:0] v, input logic exp_ack);
    logic an;
    host_u.wr_byte(v, an);
    chk_bit("data ack", exp_ack, ~an);
  endtask

  task automatic rd_chk(input logic nak);
    logic [7:0] got;
    host_u.rd_byte(nak, got);
    chk_byte("read data", 8'(mem[ptr]), got);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    link_clk = 1'b0;
    rstn = 1'b0;
    strap_en = 1'b1;
    strap_sel = 1'b0;
    to_dis = 1'b0;
    fails = 0;
    checks = 0;
    void'($urandom(32'hf06aeeee));
    #1.3;
    reset_dut(1'b1, 1'($urandom));
    addr_ph(ADDR_SEL_LOW, 1'b0, 1'b0);
    host_u.stop();
    addr_ph(ADDR_SEL_HIGH, 1'b0, 1'b0);
    wr_dat(8'h5a, 1'b0);
    host_u.stop();
    chk_bit("locked", 1'b0, addr_locked);
    my_addr = ADDR_DEFAULT;
    for (int k = 0; k < 4; k++) begin
      p = 8'($urandom);
      d = 8'($urandom);
      addr_ph(my_addr, 1'b0, 1'b1);
      wr_dat(p, 1'b1);
      wr_dat(d, 1'b1);
      host_u.stop();
      ptr = p;
      mem[p] = d;
      wq.push_back(p);
    end
    chk_bit("locked", 1'b1, addr_locked);
    foreach (wq[j]) begin
      addr_ph(my_addr, 1'b0, 1'b1);
      wr_dat(8'(wq[j]), 1'b1);
      ptr = wq[j];
      addr_ph(my_addr, 1'b1, 1'b1);
      rd_chk(1'b1);
      host_u.stop();
    end
    // an acked read still gets one byte only
    addr_ph(my_addr, 1'b1, 1'b1);
    rd_chk(1'b0);
    host_u.rd_byte(1'b1, d);
    chk_byte("extra read", 8'hff, d);
    host_u.stop();
    p = 8'($urandom);
    d = 8'($urandom);
    addr_ph(my_addr, 1'b0, 1'b1);
    wr_dat(p, 1'b1);
    wr_dat(d, 1'b1);
    wr_dat(~d, 1'b0);
    host_u.stop();
    ptr = p;
    mem[p] = d;
    addr_ph(my_addr, 1'b1, 1'b1);
    rd_chk(1'b1);
    host_u.stop();
    d = 8'($urandom);
    addr_ph(my_addr, 1'b0, 1'b1);
    wr_dat(8'h00, 1'b1);
    wr_dat(d, 1'b1);
    host_u.stop();
    mem[0] = d;
    reset_dut(1'b0, 1'b0);
    my_addr = ADDR_SEL_LOW;
    addr_ph(ADDR_DEFAULT, 1'b1, 1'b0);
    host_u.stop();
    addr_ph(ADDR_SEL_HIGH, 1'b1, 1'b0);
    host_u.stop();
    addr_ph(my_addr, 1'b1, 1'b1);
    rd_chk(1'b1);
    host_u.stop();
    strap_sel <= 1'b1;
    addr_ph(ADDR_SEL_HIGH, 1'b0, 1'b0);
    host_u.stop();
    addr_ph(my_addr, 1'b0, 1'b1);
    host_u.stop();
    reset_dut(1'b0, 1'b1);
    my_addr = ADDR_SEL_HIGH;
    addr_ph(ADDR_SEL_LOW, 1'b0, 1'b0);
    host_u.stop();
    // master freezes the clock while the device holds its ack low
    for (int k = 0; k < 2; k++) begin
      to_dis <= k[0];
      host_u.start();
      for (int i = 7; i >= 0; i--) begin
        host_u.bit_io(i == 0 ? 1'b0 : my_addr[i-1], r);
      end
      repeat (100) @(negedge clk);
      chk_bit("ack held", 1'b1, sda_oe);
      chk_bit("sda level", 1'b0, sda_o);
      repeat (160) @(negedge clk);
      chk_bit("ack after silence", k[0], sda_oe);
      host_u.bit_io(1'b1, r);
      host_u.stop();
    end
    results();
  end

  initial begin
    #2_000_000;
    fails++;
    results();
  end
endmodule
